// >>> intr_pkg.sv
// Constants shared by the interrupt output block and its helpers.
// Contract
// R1 - Enable low leaves interrupt pin undriven
// R2 - Enable high drives pin low on pending
// R3 - Mask bit one lets its flag through
// R4 - Each event sets its sticky flag
// R5 - Flag read returns flags then clears them
// R6 - Pin open drain after reset, push-pull optional
// R7 - Flag bits ordered touch conversion down to swap
// R8 - Event during clearing read keeps flag set
package intr_pkg;

   // ------------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int FLAG_W = 8;

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_INT_ENABLE = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_INT_FLAGS = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PIN_CTRL = 8'h0C;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int ENABLE_BIT = 0;
   localparam int PUSH_PULL_BIT = 0;
   localparam logic RST_ENABLE = 1'b0;
   localparam logic RST_PUSH_PULL = 1'b0;
   localparam logic [FLAG_W-1:0] RST_MASK = 8'h00;
   localparam logic [FLAG_W-1:0] RST_FLAGS = 8'h00;

   // ------------------------------------------------------------------
   // Flag bit positions
   // ------------------------------------------------------------------
   localparam int FLAG_TOUCH_CONV = 7;
   localparam int FLAG_CMD_FLAG = 6;
   localparam int FLAG_CMD_DRAINED = 5;
   localparam int FLAG_PLAYBACK = 4;
   localparam int FLAG_SOUND = 3;
   localparam int FLAG_TAG = 2;
   localparam int FLAG_TOUCH = 1;
   localparam int FLAG_SWAP = 0;

endpackage : intr_pkg

// >>> event_flag_bank.sv
// Sticky event flags with a clear-all strobe.
`timescale 1ns/1ps
module event_flag_bank
#(
   parameter int WIDTH = 8
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Events and clear
   input wire logic [WIDTH-1:0] event_set,
   input wire logic clear_all,
   // Flag state
   output logic [WIDTH-1:0] flags_reg
);
   import intr_pkg::*;

   logic [WIDTH-1:0] flags_next;

   // An event in the clearing cycle is ORed after the clear, so it survives.
   always_comb
   begin
      flags_next = clear_all ? '0 : flags_reg;  // see R5
      flags_next = flags_next | event_set;  // see R4 see R8
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         flags_reg <= WIDTH'(RST_FLAGS);
      end
      else
      begin
         flags_reg <= flags_next;
      end
   end

endmodule : event_flag_bank

// >>> int_pin_driver.sv
// Registered open-drain or push-pull driver for the interrupt pin.
`timescale 1ns/1ps
module int_pin_driver
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Control
   input wire logic drive_en,
   input wire logic pending,
   input wire logic push_pull,
   // Pin
   output logic pin_out_reg,
   output logic pin_oe_reg
);
   logic pin_out_next;
   logic pin_oe_next;

   always_comb
   begin
      if (!drive_en)
      begin
         pin_out_next = 1'b0;
         pin_oe_next = 1'b0;  // see R1
      end
      else if (push_pull)
      begin
         pin_out_next = !pending;  // see R6
         pin_oe_next = 1'b1;
      end
      else
      begin
         pin_out_next = 1'b0;
         pin_oe_next = pending;  // see R2
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pin_out_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
      end
      else
      begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

endmodule : int_pin_driver

// >>> interrupt_output_logic.sv
// Interrupt aggregation: sticky flags, mask, enable and pin drive.
`timescale 1ns/1ps
module interrupt_output_logic
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [intr_pkg::ADDR_W-1:0] addr,
   input wire logic [intr_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [intr_pkg::DATA_W-1:0] rd_data_reg,
   // Event sources, one-cycle pulses or levels
   input wire logic touch_conversion_done,
   input wire logic cmd_queue_flag,
   input wire logic cmd_queue_drained,
   input wire logic playback_done,
   input wire logic sound_done,
   input wire logic tag_changed,
   input wire logic touch_detected,
   input wire logic swap_done,
   // Interrupt pin, active low, resolved outside
   output logic int_n_out,
   output logic int_n_oe,
   // Internal level interrupt
   output logic irq_reg
);
   import intr_pkg::*;

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   function automatic logic hit
   (
      input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] off
   );
      return a == off;
   endfunction : hit

   logic wr_enable;
   logic wr_mask;
   logic wr_pin_ctrl;
   logic flag_read;

   assign wr_enable = wr_stb && hit(addr, OFF_INT_ENABLE);
   assign wr_mask = wr_stb && hit(addr, OFF_INT_MASK);
   assign wr_pin_ctrl = wr_stb && hit(addr, OFF_PIN_CTRL);
   assign flag_read = rd_stb && hit(addr, OFF_INT_FLAGS);

   // ------------------------------------------------------------------
   // Event vector
   // ------------------------------------------------------------------
   logic [FLAG_W-1:0] events;

   always_comb
   begin
      events = '0;
      events[FLAG_TOUCH_CONV] = touch_conversion_done;  // see R7
      events[FLAG_CMD_FLAG] = cmd_queue_flag;
      events[FLAG_CMD_DRAINED] = cmd_queue_drained;
      events[FLAG_PLAYBACK] = playback_done;
      events[FLAG_SOUND] = sound_done;
      events[FLAG_TAG] = tag_changed;
      events[FLAG_TOUCH] = touch_detected;
      events[FLAG_SWAP] = swap_done;
   end

   // ------------------------------------------------------------------
   // Sticky flags
   // ------------------------------------------------------------------
   logic [FLAG_W-1:0] flags_reg;

   // The clearing read and the sampled data use the same cycle's flags,
   // so nothing set before the read is lost and nothing is read twice.
   event_flag_bank #(
      .WIDTH(FLAG_W)
   ) event_flag_bank_i (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .event_set(events),  // see R4
      .clear_all(flag_read),  // see R5
      .flags_reg(flags_reg)
   );

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   logic enable_reg;
   logic [FLAG_W-1:0] mask_reg;
   logic push_pull_reg;

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         enable_reg <= RST_ENABLE;
      end
      else if (wr_enable)
      begin
         enable_reg <= wr_data[ENABLE_BIT];
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mask_reg <= RST_MASK;
      end
      else if (wr_mask)
      begin
         mask_reg <= wr_data[FLAG_W-1:0];  // see R3
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         push_pull_reg <= RST_PUSH_PULL;  // see R6
      end
      else if (wr_pin_ctrl)
      begin
         push_pull_reg <= wr_data[PUSH_PULL_BIT];  // see R6
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] rd_data_next;

   // Unmapped addresses read as zero; unmapped writes are dropped.
   always_comb
   begin
      rd_data_next = '0;
      if (hit(addr, OFF_INT_ENABLE))
      begin
         rd_data_next[ENABLE_BIT] = enable_reg;
      end
      else if (hit(addr, OFF_INT_MASK))
      begin
         rd_data_next[FLAG_W-1:0] = mask_reg;
      end
      else if (hit(addr, OFF_INT_FLAGS))
      begin
         rd_data_next[FLAG_W-1:0] = flags_reg;  // see R5
      end
      else if (hit(addr, OFF_PIN_CTRL))
      begin
         rd_data_next[PUSH_PULL_BIT] = push_pull_reg;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rd_data_reg <= '0;
      end
      else if (rd_stb)
      begin
         rd_data_reg <= rd_data_next;
      end
      else
      begin
         rd_data_reg <= '0;
      end
   end

   // ------------------------------------------------------------------
   // Pending and pin drive
   // ------------------------------------------------------------------
   logic pending;

   assign pending = |(flags_reg & mask_reg);  // see R3

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= pending;
      end
   end

   // The pin lags the flags by one cycle; the host sees no difference
   // at its own speed, and the pin stays glitch free.
   int_pin_driver int_pin_driver_i (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .drive_en(enable_reg),  // see R1
      .pending(pending),  // see R2
      .push_pull(push_pull_reg),  // see R6
      .pin_out_reg(int_n_out),
      .pin_oe_reg(int_n_oe)
   );

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking

   default disable iff (sys_rst);

   a_disabled_floats: assert property ( // see R1
      !enable_reg |=> !int_n_oe
   )
   else $error("Interrupt pin driven while disabled.");

   a_enabled_pulls_low: assert property ( // see R2
      enable_reg && pending |=> int_n_oe && !int_n_out
   )
   else $error("Pending interrupt did not drive the pin low.");

   a_od_release: assert property ( // see R2
      enable_reg && !pending && !push_pull_reg |=> !int_n_oe
   )
   else $error("Open drain pin not released when idle.");

   a_mask_blocks: assert property ( // see R3
      ((flags_reg & mask_reg) == '0) && enable_reg && !push_pull_reg
      |=> !int_n_oe && !irq_reg
   )
   else $error("Masked flag reached the interrupt pin.");

   a_flag_sticky: assert property ( // see R4
      !flag_read |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg))
   )
   else $error("Flag dropped without a clearing read.");

   a_event_sets: assert property ( // see R4
      1'b1 |=> ((flags_reg & $past(events)) == $past(events))
   )
   else $error("Event did not set its flag.");

   a_read_returns: assert property ( // see R5
      flag_read |=> rd_data_reg == DATA_W'($past(flags_reg))
   )
   else $error("Flag read returned wrong data.");

   a_read_clears: assert property ( // see R5
      flag_read |=> flags_reg == $past(events)
   )
   else $error("Flag read did not clear the flags.");

   a_clear_keeps_event: assert property ( // see R8
      flag_read && (events != '0) |=> (flags_reg != '0)
   )
   else $error("Event lost in the clearing cycle.");

   a_push_pull_high: assert property ( // see R6
      enable_reg && push_pull_reg && !pending |=> int_n_oe && int_n_out
   )
   else $error("Push-pull pin not driven high when idle.");

   a_conv_bit_top: assert property ( // see R7
      touch_conversion_done |=> flags_reg[FLAG_TOUCH_CONV]
   )
   else $error("Touch conversion event in wrong flag bit.");

   a_swap_bit_low: assert property ( // see R7
      swap_done |=> flags_reg[FLAG_SWAP]
   )
   else $error("Swap event in wrong flag bit.");

   a_irq_follows: assert property (
      pending |=> irq_reg
   )
   else $error("Interrupt level missed a pending flag.");

   a_read_quiet: assert property (
      !rd_stb |=> rd_data_reg == '0
   )
   else $error("Read data not zero outside a read.");

   a_enable_write: assert property ( // see R1
      wr_enable |=> enable_reg == $past(wr_data[ENABLE_BIT])
   )
   else $error("Enable write not taken.");

   a_mask_write: assert property ( // see R3
      wr_mask |=> mask_reg == $past(wr_data[FLAG_W-1:0])
   )
   else $error("Mask write not taken.");

   a_mode_write: assert property ( // see R6
      wr_pin_ctrl |=> push_pull_reg == $past(wr_data[PUSH_PULL_BIT])
   )
   else $error("Pin mode write not taken.");

   a_flag_exact: assert property ( // see R4
      !flag_read |=> flags_reg == ($past(flags_reg) | $past(events))
   )
   else $error("Flags changed without an event.");

   a_od_never_high: assert property ( // see R6
      !push_pull_reg |=> !(int_n_oe && int_n_out)
   )
   else $error("Open drain pin driven high.");

   a_pp_always_drives: assert property ( // see R6
      enable_reg && push_pull_reg |=> int_n_oe
   )
   else $error("Push-pull pin not driven.");

   a_irq_drops: assert property ( // see R3
      !pending |=> !irq_reg
   )
   else $error("Interrupt level set with nothing pending.");

   a_idle_released: assert property ( // see R2
      enable_reg && !pending |=> !(int_n_oe && !int_n_out)
   )
   else $error("Pin pulled low with nothing pending.");

   // ------------------------------------------------------------------
   // Coverage
   // ------------------------------------------------------------------
   c_od_assert: cover property (
      enable_reg && !push_pull_reg && pending ##1 int_n_oe
   );

   c_pp_assert: cover property (
      enable_reg && push_pull_reg && pending ##1 !int_n_out
   );

   c_read_with_event: cover property (
      flag_read && (events != '0)
   );

   c_masked_flag: cover property (
      (flags_reg != '0) && ((flags_reg & mask_reg) == '0) && enable_reg
   );

   c_pp_idle_high: cover property (
      enable_reg && push_pull_reg && !pending ##1 int_n_out
   );

endmodule : interrupt_output_logic

// >>> host_model.sv
// Host side of the interrupt pin: pull-up resistor and line monitor.
`timescale 1ns/1ps
module host_model
(
   // Pin as driven by the device
   input wire logic int_n_out,
   input wire logic int_n_oe,
   // Resolved line as the host sees it
   output logic int_n_line,
   output logic [15:0] low_count
);
   // The external pull-up holds the line high whenever the device lets go.
   assign int_n_line = int_n_oe ? int_n_out : 1'b1;

   initial
   begin
      low_count = 16'h0000;
      forever
      begin
         @(negedge int_n_line);
         low_count = low_count + 16'h0001;
      end
   end
endmodule : host_model

// >>> interrupt_output_logic_test.sv
// Self-checking testbench for the interrupt aggregation block.
`timescale 1ns/1ps
module interrupt_output_logic_test;
   import intr_pkg::*;

   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [DATA_W-1:0] wr_data = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [DATA_W-1:0] rd_data_reg;
   logic [FLAG_W-1:0] ev = 8'h00;
   logic int_n_out;
   logic int_n_oe;
   logic irq_reg;
   logic int_n_line;
   logic [15:0] low_count;
   logic [15:0] cnt0;
   int seed = 32'hd7b7_ea86;
   int n_fail = 0;
   int comparisons = 0;
   logic [7:0] got;
   logic [7:0] m;
   logic [7:0] e;
   logic en;
   logic pp;

   always #2.5 ref_clk = ~ref_clk;

   interrupt_output_logic interrupt_output_logic_i
   (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .addr(addr),
      .wr_data(wr_data),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .rd_data_reg(rd_data_reg),
      .touch_conversion_done(ev[7]),
      .cmd_queue_flag(ev[6]),
      .cmd_queue_drained(ev[5]),
      .playback_done(ev[4]),
      .sound_done(ev[3]),
      .tag_changed(ev[2]),
      .touch_detected(ev[1]),
      .swap_done(ev[0]),
      .int_n_out(int_n_out),
      .int_n_oe(int_n_oe),
      .irq_reg(irq_reg)
   );

   host_model host_model_i
   (
      .int_n_out(int_n_out),
      .int_n_oe(int_n_oe),
      .int_n_line(int_n_line),
      .low_count(low_count)
   );

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task chk(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, seen, want);
      end
   endtask : chk

   task report_and_stop;
      if (n_fail == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
   endtask : wr

   // Read data are taken in the one cycle after the strobe.
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1;
      d = rd_data_reg;
   endtask : rd

   task wait_cycles(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : wait_cycles

   // Expected pin state from enable, drive mode and pending flags.
   function automatic logic exp_oe(logic e_en, logic e_pp, logic pend);
      return e_en & (e_pp | pend);
   endfunction : exp_oe

   // ------------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------------
   initial
   begin
      #50000;
      n_fail++;
      report_and_stop;
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      wait_cycles(1);
      chk(int_n_oe, 1'b0);
      chk(int_n_line, 1'b1);
      rd(OFF_INT_ENABLE, got);
      chk(got & 8'h01, 8'h00);
      rd(OFF_PIN_CTRL, got);
      chk(got & 8'h01, 8'h00);
      rd(OFF_INT_MASK, got);
      chk(got, 8'h00);
      rd(OFF_INT_FLAGS, got);
      chk(got, 8'h00);
      // Unmapped place and the read-only flags ignore writes.
      wr(8'h10, 8'hff);
      wr(OFF_INT_FLAGS, 8'hff);
      rd(8'h10, got);
      chk(got, 8'h00);
      rd(OFF_INT_FLAGS, got);
      chk(got, 8'h00);
      // Each source lands in its own bit and stays until read.
      for (int i = 0; i < 8; i++)
      begin
         @(posedge ref_clk);
         ev <= 8'h01 << i;
         @(posedge ref_clk);
         ev <= 8'h00;
         wait_cycles(3);
         rd(OFF_INT_FLAGS, got);
         chk(got, 8'h01 << i);
         rd(OFF_INT_FLAGS, got);
         chk(got, 8'h00);
      end
      // Random mask, enable, drive mode and events; corner values first.
      for (int k = 0; k < 40; k++)
      begin
         m = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
         e = (k == 0) ? 8'hff : (k == 1) ? 8'h80 : 8'($random(seed));
         en = (k < 2) ? 1'b1 : 1'($random(seed));
         pp = (k < 2) ? 1'b0 : 1'($random(seed));
         wr(OFF_INT_MASK, m);
         wr(OFF_INT_ENABLE, {7'h00, en});
         wr(OFF_PIN_CTRL, {7'h00, pp});
         rd(OFF_INT_MASK, got);
         chk(got, m);
         cnt0 = low_count;
         @(posedge ref_clk);
         ev <= e;
         @(posedge ref_clk);
         ev <= 8'h00;
         wait_cycles(2);
         chk(int_n_oe, exp_oe(en, pp, |(e & m)));
         chk(int_n_line, !(en && ((e & m) != 8'h00)));
         chk(irq_reg, |(e & m));
         chk(8'(low_count - cnt0), {7'h00, en && ((e & m) != 8'h00)});
         rd(OFF_INT_FLAGS, got);
         chk(got, e);
         wait_cycles(2);
         chk(int_n_oe, exp_oe(en, pp, 1'b0));
         chk(int_n_line, 1'b1);
      end
      // A reset in mid-run returns pin mode, mask and flags to their defaults.
      wr(OFF_INT_MASK, 8'hff);
      wr(OFF_INT_ENABLE, 8'h01);
      wr(OFF_PIN_CTRL, 8'h01);
      @(posedge ref_clk);
      ev <= 8'h02;
      @(posedge ref_clk);
      ev <= 8'h00;
      wait_cycles(2);
      chk(int_n_line, 1'b0);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      wait_cycles(3);
      chk(int_n_oe, 1'b0);
      chk(irq_reg, 1'b0);
      @(posedge ref_clk);
      sys_rst <= 1'b0;
      wait_cycles(1);
      chk(int_n_line, 1'b1);
      rd(OFF_PIN_CTRL, got);
      chk(got, 8'h00);
      rd(OFF_INT_MASK, got);
      chk(got, 8'h00);
      rd(OFF_INT_FLAGS, got);
      chk(got, 8'h00);
      // Back in open drain, the idle pin is released, not driven high.
      wr(OFF_INT_ENABLE, 8'h01);
      wr(OFF_INT_MASK, 8'hff);
      @(posedge ref_clk);
      ev <= 8'h20;
      @(posedge ref_clk);
      ev <= 8'h00;
      wait_cycles(2);
      chk(int_n_line, 1'b0);
      rd(OFF_INT_FLAGS, got);
      chk(got, 8'h20);
      wait_cycles(2);
      chk(int_n_oe, 1'b0);
      // An event in the cycle of the clearing read is kept.
      @(posedge ref_clk);
      ev <= 8'h01;
      @(posedge ref_clk);
      ev <= 8'h08;
      addr <= OFF_INT_FLAGS;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      ev <= 8'h00;
      rd_stb <= 1'b0;
      #1;
      chk(rd_data_reg, 8'h01);
      wait_cycles(1);
      chk(rd_data_reg, 8'h00);
      rd(OFF_INT_FLAGS, got);
      chk(got, 8'h08);
      report_and_stop;
   end
endmodule : interrupt_output_logic_test
